//--- rtl/fsg_regs.svh
// register offsets, field positions, reset values and timing counts for the signature block
`ifndef FSG_REGS_SVH
`define FSG_REGS_SVH

`define FSG_OFF_BEGIN      12'h020
`define FSG_OFF_END        12'h024
`define FSG_OFF_WORD0      12'h02c
`define FSG_OFF_WORD1      12'h030
`define FSG_OFF_WORD2      12'h034
`define FSG_OFF_WORD3      12'h038
`define FSG_OFF_STATUS     12'hfe0
`define FSG_OFF_STATUS_CLR 12'hfe8

`define FSG_ADDR_MSB       16
`define FSG_LAUNCH_BIT     17
`define FSG_COMPLETE_BIT   2

`define FSG_ADDR_RESET     17'h00000
`define FSG_SIG_RESET      128'h0

`define FSG_CLK_PERIOD_NS  40
`define FSG_READ_TIME_NS   60
`define FSG_READ_CYCLES    ((`FSG_READ_TIME_NS + `FSG_CLK_PERIOD_NS - 1) / `FSG_CLK_PERIOD_NS)
`define FSG_STEP_BUDGET    ((`FSG_READ_TIME_NS / `FSG_CLK_PERIOD_NS) + 3)

`endif

//--- rtl/fsg_pkg.sv
// types shared by the flash signature generator
`default_nettype none
package fsg_pkg;
  typedef logic [16:0] fsg_addr_type;
  typedef logic [127:0] fsg_word_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } fsg_bus_req_type;

  typedef struct packed {
    logic         req;
    fsg_addr_type addr;
  } fsg_flash_req_type;

  typedef struct packed {
    logic         valid;
    fsg_word_type data;
    logic [15:0]  check;
  } fsg_flash_rsp_type;

  typedef enum logic [1:0] {
    FSG_IDLE  = 2'b00,
    FSG_ISSUE = 2'b01,
    FSG_WAIT  = 2'b10,
    FSG_FINAL = 2'b11
  } fsg_state_type;
endpackage
`default_nettype wire

//--- rtl/fsg_result_mem.sv
// four-word result store with registered read data
`default_nettype none
module fsg_result_mem
  import fsg_pkg::*;
(
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_load,
  input  wire fsg_word_type i_sig,
  input  wire logic         i_rd,
  input  wire logic [1:0]   i_rd_sel,
  output logic [31:0]       o_rd_data
);
  logic [31:0] mem_r [0:3];

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      for (int k = 0; k < 4; k++) begin
        mem_r[k] <= 32'h0;
      end
    end else if (i_load) begin
      for (int k = 0; k < 4; k++) begin
        mem_r[k] <= i_sig[k*32 +: 32];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_rd_data <= 32'h0;
    end else if (i_rd) begin
      o_rd_data <= mem_r[i_rd_sel];
    end else begin
      o_rd_data <= 32'h0;
    end
  end
endmodule // fsg_result_mem
`default_nettype wire

//--- rtl/fsg_top.sv
// flash signature generator: register port, range sequencer and signature register
`include "fsg_regs.svh"
`default_nettype none
module fsg_top
  import fsg_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_n,
  input  wire fsg_bus_req_type   i_bus,
  output logic [31:0]            o_rdata,
  output fsg_flash_req_type      o_flash,
  input  wire fsg_flash_rsp_type i_flash,
  output logic                   o_busy
);
  //////////////////////////////////////////////////////////////////////////////
  // signature step

  // one compaction step, with the check bits folded into the low bits first
  function automatic fsg_word_type fsg_step(input fsg_word_type sig,
                                            input fsg_word_type data,
                                            input logic [15:0] chk);
    fsg_word_type w;
    fsg_word_type n;
    w = data ^ {112'h0, chk};
    for (int k = 0; k < 127; k++) begin
      n[k] = w[k] ^ sig[k+1];
    end
    n[127] = w[127] ^ sig[0] ^ sig[2] ^ sig[27] ^ sig[29];
    return n;
  endfunction

  function automatic logic fsg_hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // registers

  fsg_state_type state_r;
  fsg_state_type state_nxt;
  fsg_addr_type  begin_r;
  fsg_addr_type  end_r;
  fsg_addr_type  cur_r;
  fsg_word_type  sig_r;
  logic          complete_r;
  logic [31:0]   reg_rdata_r;
  logic [31:0]   mem_rdata;
  logic          mem_sel_r;
  logic          launch;
  logic          wr_end;
  logic          finish;

  assign wr_end  = i_bus.wr && fsg_hit(i_bus.addr, `FSG_OFF_END);
  // a launch while busy is dropped, not queued
  assign launch  = wr_end && i_bus.wdata[`FSG_LAUNCH_BIT] && (state_r == FSG_IDLE);
  assign finish  = (state_r == FSG_FINAL);
  assign o_busy  = (state_r != FSG_IDLE);

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      begin_r <= `FSG_ADDR_RESET;
    end else if (i_bus.wr && fsg_hit(i_bus.addr, `FSG_OFF_BEGIN) && !o_busy) begin
      begin_r <= i_bus.wdata[`FSG_ADDR_MSB:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      end_r <= `FSG_ADDR_RESET;
    end else if (wr_end && !o_busy) begin
      end_r <= i_bus.wdata[`FSG_ADDR_MSB:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FSG_IDLE:  if (launch) state_nxt = FSG_ISSUE;
      FSG_ISSUE: state_nxt = FSG_WAIT;
      FSG_WAIT: begin
        if (i_flash.valid) begin
          state_nxt = (cur_r == end_r) ? FSG_FINAL : FSG_ISSUE;
        end
      end
      FSG_FINAL: state_nxt = FSG_IDLE;
      default:   state_nxt = FSG_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state_r <= FSG_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // start address is sampled at launch; end address comes from the same write
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cur_r <= `FSG_ADDR_RESET;
    end else if (launch) begin
      cur_r <= begin_r;
    end else if (state_r == FSG_WAIT && i_flash.valid && cur_r != end_r) begin
      cur_r <= cur_r + 17'h00001;
    end
  end

  // the flash answers on its own self-timed read, no wait-state input exists here
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_flash <= '0;
    end else begin
      o_flash.req  <= (state_nxt == FSG_ISSUE);
      o_flash.addr <= (launch) ? begin_r : ((state_nxt == FSG_ISSUE) ? cur_r + 17'h00001 : cur_r);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      sig_r <= `FSG_SIG_RESET;
    end else if (launch) begin
      sig_r <= `FSG_SIG_RESET;
    end else if (state_r == FSG_WAIT && i_flash.valid) begin
      sig_r <= fsg_step(sig_r, i_flash.data, i_flash.check);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // completion flag

  logic clr_wr;
  assign clr_wr = i_bus.wr && fsg_hit(i_bus.addr, `FSG_OFF_STATUS_CLR)
                  && i_bus.wdata[`FSG_COMPLETE_BIT];

  // completion wins over a clear in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      complete_r <= 1'b0;
    end else if (finish) begin
      complete_r <= 1'b1;
    end else if (clr_wr) begin
      complete_r <= 1'b0;
    end
  end

  fsg_result_mem u_result (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_load    (finish),
    .i_sig     (sig_r),
    .i_rd      (i_bus.rd),
    .i_rd_sel  (i_bus.addr[3:2] - 2'b11),
    .o_rd_data (mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // read port

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      reg_rdata_r <= 32'h0;
      mem_sel_r   <= 1'b0;
    end else begin
      mem_sel_r   <= i_bus.rd && (fsg_hit(i_bus.addr, `FSG_OFF_WORD0)
                     || fsg_hit(i_bus.addr, `FSG_OFF_WORD1)
                     || fsg_hit(i_bus.addr, `FSG_OFF_WORD2)
                     || fsg_hit(i_bus.addr, `FSG_OFF_WORD3));
      reg_rdata_r <= 32'h0;
      if (i_bus.rd) begin
        case (i_bus.addr)
          `FSG_OFF_BEGIN:  reg_rdata_r <= {15'h0, begin_r};
          `FSG_OFF_END:    reg_rdata_r <= {14'h0, o_busy, end_r};
          `FSG_OFF_STATUS: reg_rdata_r <= {29'h0, complete_r, 2'b00};
          default:         reg_rdata_r <= 32'h0;
        endcase
      end
    end
  end

  assign o_rdata = mem_sel_r ? mem_rdata : reg_rdata_r;
endmodule // fsg_top
`default_nettype wire

//--- sim/fsg_checker.sv
// port assertions for the flash signature generator
`include "fsg_regs.svh"
`default_nettype none
module fsg_checker
  import fsg_pkg::*;
(
  input wire logic              i_ref_clk,
  input wire logic              i_rst_n,
  input wire fsg_bus_req_type   i_bus,
  input wire logic [31:0]       o_rdata,
  input wire fsg_flash_req_type o_flash,
  input wire fsg_flash_rsp_type i_flash,
  input wire logic              o_busy
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic         seen_r;
  fsg_addr_type last_r;
  wire logic    go = i_bus.wr && i_bus.addr == `FSG_OFF_END && i_bus.wdata[`FSG_LAUNCH_BIT];
  // seen_r: this run already asked for a word, so the next one must follow on
  always_ff @(posedge i_ref_clk) begin
    seen_r <= i_rst_n && o_busy && (seen_r || o_flash.req);
    if (o_flash.req) begin
      last_r <= o_flash.addr;
    end
  end
  property p_go; !o_busy && go |=> o_busy && o_flash.req; endproperty
  a_go: assert property (p_go) else $error("no start");
  property p_step; o_flash.req && seen_r |-> o_flash.addr == last_r + 17'h1; endproperty
  a_step: assert property (p_step) else $error("bad step");
  property p_pulse; o_flash.req |=> !o_flash.req; endproperty
  a_pulse: assert property (p_pulse) else $error("long req");
  property p_idle; !o_busy |-> !o_flash.req; endproperty
  a_idle: assert property (p_idle) else $error("idle req");
  property p_gap; o_flash.req |-> ##[1:8] (o_flash.req || !o_busy); endproperty
  a_gap: assert property (p_gap) else $error("slow step");
  property p_done;
    $fell(o_busy) |-> $past(i_flash.valid) || $past(i_flash.valid, 2) || $past(i_flash.valid, 3);
  endproperty
  a_done: assert property (p_done) else $error("early end");
  property p_quiet; !i_bus.rd |=> o_rdata == 32'h0; endproperty
  a_quiet: assert property (p_quiet) else $error("stray data");
  property p_endrd; i_bus.rd && i_bus.addr == `FSG_OFF_END |=> o_rdata[17] == $past(o_busy);
  endproperty
  a_endrd: assert property (p_endrd) else $error("bad launch bit");
  c_go: cover property (!o_busy && go);
  c_busy_go: cover property (o_busy && go);
  c_end: cover property ($fell(o_busy));
endmodule // fsg_checker
bind fsg_top fsg_checker fsg_checker_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
  .i_bus(i_bus), .o_rdata(o_rdata), .o_flash(o_flash), .i_flash(i_flash), .o_busy(o_busy));
`default_nettype wire

//--- sim/fsg_flash_model.sv
// flash read port model with a self-timed latency chosen by i_slow
`default_nettype none
module fsg_flash_model
  import fsg_pkg::*;
(
  input wire logic              i_ref_clk,
  input wire logic              i_slow,
  input wire fsg_flash_req_type i_req,
  output fsg_flash_rsp_type     o_rsp = '0
);
  timeunit 1ns;
  timeprecision 1ns;
  fsg_addr_type a_r;
  fsg_addr_type cur;
  logic [1:0]   w_r = 2'h0;
  function automatic fsg_word_type word_of(input fsg_addr_type a);
    return {4{15'h0, a}} * 128'h9e3779b97f4a7c15f39cc0605cedc835;
  endfunction
  // lines flip between answers so a stale word never passes as fresh
  always @(posedge i_ref_clk) begin
    cur = i_req.req ? i_req.addr : a_r;
    o_rsp <= '{1'b0, ~o_rsp.data, ~o_rsp.check};
    if (w_r != 2'h0) begin
      w_r <= w_r - 2'h1;
    end
    if (i_req.req) begin
      a_r <= i_req.addr;
      w_r <= i_slow ? 2'h2 : 2'h0;
    end
    if (i_req.req && !i_slow || w_r == 2'h1) begin
      o_rsp <= '{1'b1, word_of(cur), cur[15:0] ^ 16'hc3a5};
    end
  end
endmodule // fsg_flash_model
`default_nettype wire

//--- sim/test_fsg_top.sv
// self-checking bench for the flash signature generator
`include "fsg_regs.svh"
`default_nettype none
module test_fsg_top
  import fsg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              slow = 1'b0;
  logic              pend = 1'b0;
  fsg_bus_req_type   bus = '0;
  logic [31:0]       rdata;
  fsg_flash_req_type freq;
  fsg_flash_rsp_type frsp;
  logic              busy;
  logic [31:0]       expq[$];
  fsg_word_type      sig = '0;
  int                miscompares = 0;
  int                checks = 0;
  int                b;
  int                n;
  fsg_top fsg_top_inst (.i_ref_clk(clk), .i_rst_n(rst_n), .i_bus(bus), .o_rdata(rdata),
    .o_flash(freq), .i_flash(frsp), .o_busy(busy));
  fsg_flash_model fsg_flash_model_inst (.i_ref_clk(clk), .i_slow(slow), .i_req(freq),
    .o_rsp(frsp));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // a gap cycle after each strobe keeps one assignment per time step
  task automatic op(input logic w, input logic [11:0] a, input logic [31:0] d);
    bus <= '{w, !w, a, d};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    expq.push_back(e);
    op(1'b0, a, 32'h0);
  endtask
  task automatic cmp_cycles(input int c, input int lim);
    checks++;
    if (c > lim) begin
      miscompares++;
      $display("BAD cycles expected at most %0d seen %0d", lim, c);
    end
  endtask
  // same content pattern as the flash model holds
  function automatic fsg_word_type flash_word(input fsg_addr_type a);
    return {4{15'h0, a}} * 128'h9e3779b97f4a7c15f39cc0605cedc835;
  endfunction
  always @(posedge clk) begin
    if (pend) begin
      cmp("rdata", expq.pop_front(), rdata);
    end
    pend <= bus.rd;
  end
  task automatic run(input fsg_addr_type s, input fsg_addr_type e, input int lim);
    int c;
    fsg_word_type w;
    c = 1;
    op(1'b1, `FSG_OFF_BEGIN, {15'h0, s});
    op(1'b1, `FSG_OFF_END, {14'h0, 1'b1, e});
    if (slow) begin
      op(1'b1, `FSG_OFF_END, {14'h0, 1'b1, ~e});
      op(1'b1, `FSG_OFF_BEGIN, 32'h0);
      rd(`FSG_OFF_WORD0, sig[31:0]);
      rd(`FSG_OFF_END, {14'h0, 1'b1, e});
    end
    @(negedge clk);
    while (busy === 1'b1 && c < 4000) begin
      @(negedge clk);
      c++;
    end
    @(posedge clk);
    cmp_cycles(c, lim);
    sig = '0;
    for (int a = s; a <= e; a++) begin
      w = flash_word(17'(a)) ^ 128'(16'(a) ^ 16'hc3a5);
      sig = {w[127] ^ sig[0] ^ sig[2] ^ sig[27] ^ sig[29], w[126:0] ^ sig[127:1]};
    end
    rd(`FSG_OFF_STATUS, 32'h4);
    for (int i = 0; i < 4; i++) begin
      rd(`FSG_OFF_WORD0 + 12'(4 * i), sig[32 * i +: 32]);
    end
    rd(`FSG_OFF_BEGIN, {15'h0, s});
    rd(`FSG_OFF_END, {15'h0, e});
    op(1'b1, `FSG_OFF_STATUS_CLR, 32'h4);
    rd(`FSG_OFF_STATUS, 32'h0);
    $display("run %h to %h done", s, e);
  endtask
  initial begin
    b = $urandom(32'h2dbd1fdf);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`FSG_OFF_END, 32'h0);
    rd(`FSG_OFF_STATUS, 32'h0);
    rd(`FSG_OFF_WORD3, 32'h0);
    rd(12'h100, 32'h0);
    $display("reset values done");
    // per-word budget is int(60/40 + 3) = 4 cycles
    run(17'h1ffff, 17'h1ffff, 4);
    for (int k = 0; k < 2; k++) begin
      b = $urandom % 32'h1fff0;
      n = 4 + $urandom % 6;
      slow <= k[0];
      // the slow model answers later than a real self-timed read: one spare cycle per word
      run(17'(b), 17'(b + n - 1), k ? 5 * n : 4 * n);
    end
    close_out;
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out;
  end
endmodule // test_fsg_top
`default_nettype wire
